//--- core/arb_pkg.sv
package arb_pkg;

  // ==========================================================
  // widths
  localparam int AXW    = 12;
  localparam int DW     = 32;
  localparam int WAW    = 10;
  localparam int N_INST = 4;
  localparam int N_STAT = 16;
  localparam int RD_LAT = 3;

  // ==========================================================
  // byte offsets
  localparam logic [11:0] OFS_SSEN     = 12'h000;
  localparam logic [11:0] OFS_MCEN     = 12'h004;
  localparam logic [11:0] OFS_MAC_LO   = 12'h040;
  localparam logic [11:0] OFS_MAC_HI   = 12'h044;
  localparam logic [11:0] OFS_IP       = 12'h048;
  localparam logic [11:0] OFS_WIN_BASE = 12'h200;
  localparam logic [11:0] OFS_WIN_SPAN = 12'h080;
  localparam logic [11:0] OFS_VER_BASE = 12'h600;
  localparam logic [11:0] OFS_STAT     = 12'h800;

  // ==========================================================
  // field positions and reset values
  localparam int          SSEN_W     = 16;
  localparam int          MCEN_BIT   = 0;
  localparam int          MAC_HI_W   = 16;
  localparam int          PORT_W     = 16;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;

  typedef enum logic [1:0] {
    RG_RX   = 2'b00,
    RG_VER  = 2'b01,
    RG_STAT = 2'b10
  } arb_region_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_WR_STB  = 3'b001,
    ST_WR_RSP  = 3'b010,
    ST_RD_REQ  = 3'b011,
    ST_RD_WAIT = 3'b100,
    ST_RD_RSP  = 3'b101
  } arb_state_t;

  function automatic logic [WAW-1:0] word_of(input logic [11:0] b);
    return b[11:2];
  endfunction

  // upper word address bits pick the region
  function automatic arb_region_t region_of(input logic [WAW-1:0] w);
    if (w >= word_of(OFS_STAT))
      return RG_STAT;
    else if (w >= word_of(OFS_VER_BASE))
      return RG_VER;
    else
      return RG_RX;
  endfunction

endpackage

//--- core/arb_rx_param_bank.sv
`timescale 1ns/1ps
module arb_rx_param_bank import arb_pkg::*; (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // register write side
  input  wire logic                 reg_write_strobe,
  input  wire logic [WAW-1:0]       reg_word_addr,
  input  wire logic [DW-1:0]        reg_write_word,
  // receiver parameters
  output logic [SSEN_W-1:0]         session_enables,
  output logic                      multicast_accept,
  output logic [47:0]               local_mac,
  output logic [31:0]               local_ip,
  output logic [N_INST*PORT_W-1:0]  session0_local_port
);

  logic wr_rx;
  assign wr_rx = reg_write_strobe && (region_of(reg_word_addr) == RG_RX);

  // ==========================================================
  // shared words, whole-word writes only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      session_enables  <= RST_WORD[SSEN_W-1:0];
      multicast_accept <= RST_WORD[MCEN_BIT];
      local_mac        <= {RST_WORD[MAC_HI_W-1:0], RST_WORD};
      local_ip         <= RST_WORD;
    end else if (wr_rx) begin
      if (reg_word_addr == word_of(OFS_SSEN))
        session_enables <= reg_write_word[SSEN_W-1:0];
      if (reg_word_addr == word_of(OFS_MCEN))
        multicast_accept <= reg_write_word[MCEN_BIT];
      if (reg_word_addr == word_of(OFS_MAC_LO))
        local_mac[31:0] <= reg_write_word;
      if (reg_word_addr == word_of(OFS_MAC_HI))
        local_mac[47:32] <= reg_write_word[MAC_HI_W-1:0];
      if (reg_word_addr == word_of(OFS_IP))
        local_ip <= reg_write_word;
    end
  end

  // ==========================================================
  // one window per instance
  for (genvar n = 0; n < N_INST; n++) begin : g_win
    localparam logic [11:0] WIN_OFS = OFS_WIN_BASE + 12'(n) * OFS_WIN_SPAN;
    always_ff @(posedge clk) begin
      if (sys_rst)
        session0_local_port[n*PORT_W +: PORT_W] <= RST_WORD[PORT_W-1:0];
      else if (wr_rx && reg_word_addr == word_of(WIN_OFS))
        session0_local_port[n*PORT_W +: PORT_W] <= reg_write_word[PORT_W-1:0];
    end
  end

endmodule // arb_rx_param_bank

//--- core/arb_read_pipe.sv
`timescale 1ns/1ps
module arb_read_pipe import arb_pkg::*; (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // read request
  input  wire logic                  reg_read_request,
  input  wire logic [WAW-1:0]        reg_word_addr,
  // status sources
  input  wire logic [N_STAT*DW-1:0]  status_words,
  // read answer
  output logic                       reg_read_valid,
  output logic [DW-1:0]              reg_read_word
);

  logic [DW-1:0] grp_ff [4];
  logic [DW-1:0] pick_ff;
  logic [1:0]    sel_ff;
  logic          hit1_ff;
  logic          hit2_ff;
  logic [2:0]    req_ff;

  // ==========================================================
  // request delay line
  always_ff @(posedge clk) begin
    if (sys_rst)
      req_ff <= 3'h0;
    else
      req_ff <= {req_ff[1:0], reg_read_request};
  end
  assign reg_read_valid = req_ff[2];

  // ==========================================================
  // stage 1: four 4-input muxes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int g = 0; g < 4; g++)
        grp_ff[g] <= RST_WORD;
      sel_ff  <= 2'h0;
      hit1_ff <= 1'b0;
    end else begin
      for (int g = 0; g < 4; g++)
        grp_ff[g] <= status_words[(g*4 + int'(reg_word_addr[1:0]))*DW +: DW];
      sel_ff  <= reg_word_addr[3:2];
      hit1_ff <= (region_of(reg_word_addr) == RG_STAT) &&
                 (reg_word_addr[WAW-2:4] == '0);
    end
  end

  // ==========================================================
  // stage 2 and 3: final mux, zero outside status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pick_ff       <= RST_WORD;
      hit2_ff       <= 1'b0;
      reg_read_word <= RST_WORD;
    end else begin
      pick_ff       <= grp_ff[sel_ff];
      hit2_ff       <= hit1_ff;
      reg_read_word <= hit2_ff ? pick_ff : RST_WORD;
    end
  end

endmodule // arb_read_pipe

//--- core/arb_axil_regbank.sv
// How it works
// - write and read paths, and their address/data channels, handshake separately
// - one word address bus, loaded from write or read address channel
// - never a register write and register read in the same cycle
// - write strobe pulses with address, data and byte enables together
// - lane mask bit n qualifies data byte n
// - read request pulses with address; slave returns one 32-bit word
// - address held from read request until read valid
// - read word with valid is forwarded on the read data channel
// - regions: receiver params, verifier params, read-only status
// - upper address bits pick region, lower bits pick register
// - registers written as whole words, lane mask ignored
// - read valid is the request delayed by three flip-flops
// - status read built from small multiplexers in stages
// - word 0x0 holds sixteen session enables, four per receiver
// - bit 0 of word 0x4 drives the shared multicast enable
// - local MAC: low 32 bits at 0x40, high 16 at 0x44
// - local IP address held in word 0x48
// - each receiver has a 128-byte window starting at 0x200
// - first window word bits 15..0 hold session 0 local port
`timescale 1ns/1ps
module arb_axil_regbank import arb_pkg::*; (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // write address channel
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [AXW-1:0]        s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  // write data channel
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [DW-1:0]         s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // write response channel
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // read address channel
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [AXW-1:0]        s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  // read data channel
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [DW-1:0]              s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // status from receivers and checker
  input  wire logic [N_STAT*DW-1:0]  status_words,
  // receiver parameters
  output logic [SSEN_W-1:0]          session_enables,
  output logic                       multicast_accept,
  output logic [47:0]                local_mac,
  output logic [31:0]                local_ip,
  output logic [N_INST*PORT_W-1:0]   session0_local_port
);

  // ==========================================================
  // bridge state
  arb_state_t      state_ff;
  arb_state_t      nxt_state;
  logic            aw_held_ff;
  logic            w_held_ff;
  logic            awready_ff;
  logic            wready_ff;
  logic            arready_ff;
  logic            bvalid_ff;
  logic            rvalid_ff;
  logic [DW-1:0]   rdata_ff;

  // register side
  logic [WAW-1:0]  reg_word_addr_ff;
  logic [DW-1:0]   reg_write_word_ff;
  logic [3:0]      reg_write_lane_mask_ff;
  logic            reg_write_strobe;
  logic            reg_read_request;
  logic            reg_read_valid;
  logic [DW-1:0]   reg_read_word;

  logic            aw_hs;
  logic            w_hs;
  logic            ar_hs;
  logic            idle_free;

  assign aw_hs = s_axi_awvalid && awready_ff;
  assign w_hs  = s_axi_wvalid && wready_ff;
  assign ar_hs = s_axi_arvalid && arready_ff;

  // nothing in flight and no ready raised yet
  assign idle_free = (state_ff == ST_IDLE) && !aw_held_ff && !w_held_ff &&
                     !awready_ff && !wready_ff && !arready_ff;

  assign reg_write_strobe = (state_ff == ST_WR_STB);
  assign reg_read_request = (state_ff == ST_RD_REQ);

  // ==========================================================
  // write address and data capture, each its own handshake
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
    end else begin
      if (aw_hs) begin
        awready_ff <= 1'b0;
        aw_held_ff <= 1'b1;
      end else if (idle_free && (s_axi_awvalid || s_axi_wvalid)) begin
        awready_ff <= 1'b1;
      end else if (state_ff == ST_WR_STB) begin
        aw_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b0;
    end else begin
      if (w_hs) begin
        wready_ff <= 1'b0;
        w_held_ff <= 1'b1;
      end else if (idle_free && (s_axi_awvalid || s_axi_wvalid)) begin
        wready_ff <= 1'b1;
      end else if (state_ff == ST_WR_STB) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // reads only start while no write is in flight
  always_ff @(posedge clk) begin
    if (sys_rst)
      arready_ff <= 1'b0;
    else if (ar_hs)
      arready_ff <= 1'b0;
    else if (idle_free && !s_axi_awvalid && !s_axi_wvalid && s_axi_arvalid)
      arready_ff <= 1'b1;
  end

  // ==========================================================
  // shared register address and write data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_word_addr_ff       <= '0;
      reg_write_word_ff      <= RST_WORD;
      reg_write_lane_mask_ff <= 4'h0;
    end else begin
      if (aw_hs)
        reg_word_addr_ff <= word_of(s_axi_awaddr);
      else if (ar_hs)
        reg_word_addr_ff <= word_of(s_axi_araddr);
      if (w_hs) begin
        reg_write_word_ff      <= s_axi_wdata;
        reg_write_lane_mask_ff <= s_axi_wstrb;
      end
    end
  end

  // ==========================================================
  // sequencing of both directions
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (aw_held_ff && w_held_ff)
          nxt_state = ST_WR_STB;
        else if (ar_hs)
          nxt_state = ST_RD_REQ;
      end
      ST_WR_STB:  nxt_state = ST_WR_RSP;
      ST_WR_RSP: begin
        if (s_axi_bready)
          nxt_state = ST_IDLE;
      end
      ST_RD_REQ:  nxt_state = ST_RD_WAIT;
      ST_RD_WAIT: begin
        if (reg_read_valid)
          nxt_state = ST_RD_RSP;
      end
      ST_RD_RSP: begin
        if (s_axi_rready)
          nxt_state = ST_IDLE;
      end
      default:    nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // ==========================================================
  // responses, always OKAY
  always_ff @(posedge clk) begin
    if (sys_rst)
      bvalid_ff <= 1'b0;
    else if (state_ff == ST_WR_STB)
      bvalid_ff <= 1'b1;
    else if (bvalid_ff && s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= RST_WORD;
    end else if (state_ff == ST_RD_WAIT && reg_read_valid) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= reg_read_word;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = RESP_OKAY;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = RESP_OKAY;

  // ==========================================================
  // register file and read path
  arb_rx_param_bank u_rx_param_bank (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .reg_write_strobe    (reg_write_strobe),
    .reg_word_addr       (reg_word_addr_ff),
    .reg_write_word      (reg_write_word_ff),
    .session_enables     (session_enables),
    .multicast_accept    (multicast_accept),
    .local_mac           (local_mac),
    .local_ip            (local_ip),
    .session0_local_port (session0_local_port)
  );

  arb_read_pipe u_read_pipe (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .reg_read_request (reg_read_request),
    .reg_word_addr    (reg_word_addr_ff),
    .status_words     (status_words),
    .reg_read_valid   (reg_read_valid),
    .reg_read_word    (reg_read_word)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rd_issue;
    reg_read_request;
  endsequence

  sequence s_rd_return;
    ##3 reg_read_valid;
  endsequence

  property p_no_collide;
    !(reg_write_strobe && reg_read_request);
  endproperty
  a_no_collide: assert property (p_no_collide)
    else $error("write strobe and read request together");

  property p_rd_latency;
    s_rd_issue |-> s_rd_return;
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("read valid not three cycles after request");

  property p_addr_hold;
    s_rd_issue |=> $stable(reg_word_addr_ff) [*3];
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("register address moved during read");

  property p_forward;
    (state_ff == ST_RD_WAIT && reg_read_valid) |=>
      s_axi_rvalid && s_axi_rdata == $past(reg_read_word);
  endproperty
  a_forward: assert property (p_forward)
    else $error("read word not forwarded");

  property p_wr_resp;
    reg_write_strobe |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing after strobe");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped before accept");

  property p_ssen;
    reg_write_strobe && reg_word_addr_ff == word_of(OFS_SSEN) |=>
      session_enables == $past(reg_write_word_ff[SSEN_W-1:0]);
  endproperty
  a_ssen: assert property (p_ssen)
    else $error("session enables not written");

  property p_mcen;
    reg_write_strobe && reg_word_addr_ff == word_of(OFS_MCEN) |=>
      multicast_accept == $past(reg_write_word_ff[MCEN_BIT]);
  endproperty
  a_mcen: assert property (p_mcen)
    else $error("multicast enable not written");

  property p_full_word;
    reg_write_strobe && reg_word_addr_ff == word_of(OFS_IP) |=>
      local_ip == $past(reg_write_word_ff);
  endproperty
  a_full_word: assert property (p_full_word)
    else $error("local ip not written as a whole word");

  property p_ro_write;
    reg_write_strobe && region_of(reg_word_addr_ff) == RG_STAT |=>
      $stable(session_enables) && $stable(local_ip) && $stable(local_mac);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write to status region changed a register");

  property p_wo_read_zero;
    s_rd_issue and (region_of(reg_word_addr_ff) != RG_STAT) |->
      ##3 (reg_read_word == RST_WORD);
  endproperty
  a_wo_read_zero: assert property (p_wo_read_zero)
    else $error("read of write-only region not zero");

  property p_lane_mask;
    reg_write_strobe |-> $stable(reg_write_lane_mask_ff) && w_held_ff;
  endproperty
  a_lane_mask: assert property (p_lane_mask)
    else $error("write strobe without held data and mask");

endmodule // arb_axil_regbank

//--- tb/arb_cpu_model.sv
`timescale 1ns/1ps
module arb_cpu_model import arb_pkg::*; (
  // clock
  input  wire logic        clk,
  // write address and data
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [AXW-1:0]   s_axi_awaddr,
  output logic [2:0]       s_axi_awprot,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [DW-1:0]    s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  // write response
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  // read address and data
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [AXW-1:0]   s_axi_araddr,
  output logic [2:0]       s_axi_arprot,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [DW-1:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 30'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
  end

  // ==========================================================
  // write: address at once, data after wdly edges
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           input int wdly, output logic [1:0] resp);
    int n;
    bit aw_ok, w_ok;
    n = 0;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    forever begin
      if (n == wdly) begin
        s_axi_wvalid <= 1'b1;
        s_axi_wdata  <= d;
        s_axi_wstrb  <= s;
      end
      @(posedge clk);
      n++;
      // released address and data show the inverse, never the old value
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
        aw_ok = 1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
        w_ok = 1;
      end
      if (aw_ok && w_ok) break;
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // ==========================================================
  // read: ready for data after rdly edges, lat counts edges to rvalid
  task automatic axi_read(input logic [11:0] a, input int rdly, output logic [31:0] d,
                          output logic [1:0] resp, output int lat);
    int n;
    lat = 0;
    n = 0;
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    forever begin
      @(posedge clk);
      n++;
      if (s_axi_rvalid === 1'b1 && lat == 0) lat = n;
      if (s_axi_rvalid === 1'b1 && s_axi_rready) break;
      if (n >= rdly) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // arb_cpu_model

//--- tb/arb_axil_regbank_tb.sv
`timescale 1ns/1ps
module arb_axil_regbank_tb import arb_pkg::*;;
  logic                     clk, sys_rst;
  logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                     s_axi_rvalid, s_axi_rready;
  logic [AXW-1:0]           s_axi_awaddr, s_axi_araddr;
  logic [2:0]               s_axi_awprot, s_axi_arprot;
  logic [DW-1:0]            s_axi_wdata, s_axi_rdata;
  logic [3:0]               s_axi_wstrb;
  logic [1:0]               s_axi_bresp, s_axi_rresp;
  logic [N_STAT*DW-1:0]     status_words;
  logic [SSEN_W-1:0]        session_enables;
  logic                     multicast_accept;
  logic [47:0]              local_mac;
  logic [31:0]              local_ip;
  logic [N_INST*PORT_W-1:0] session0_local_port;
  int                       n_errors, comparisons, cycles;

  arb_axil_regbank i_arb_axil_regbank (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .status_words, .session_enables, .multicast_accept, .local_mac, .local_ip,
    .session0_local_port);

  arb_cpu_model i_arb_cpu_model (.clk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ==========================================================
  // helpers
  function automatic logic [31:0] stat_word(input int k);
    return 32'h5a5a_0000 + 32'(k) * 32'h0000_0101;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input int wdly);
    logic [1:0] r;
    i_arb_cpu_model.axi_write(a, d, s, wdly, r);
    check(64'(r), 64'(RESP_OKAY));
  endtask

  task automatic rd(input logic [11:0] a, input int dly, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    int          lat;
    i_arb_cpu_model.axi_read(a, dly, d, r, lat);
    check(64'(d), 64'(exp));
    check(64'(r), 64'(RESP_OKAY));
    check(64'(lat), 64'(RD_LAT + 2));
  endtask

  task automatic chk_outs(input logic [15:0] se, input logic mc, input logic [47:0] mac,
                          input logic [31:0] ip, input logic [63:0] ports);
    check(64'(session_enables), 64'(se));
    check(64'(multicast_accept), 64'(mc));
    check(64'(local_mac), 64'(mac));
    check(64'(local_ip), 64'(ip));
    check(session0_local_port, ports);
  endtask

  // ==========================================================
  // no awready or arready while a response is outstanding; hang limit
  always @(posedge clk) begin
    cycles++;
    if (!sys_rst && (s_axi_rvalid === 1'b1 || s_axi_bvalid === 1'b1))
      check(64'({s_axi_awready, s_axi_arready}), 64'h0);
    if (cycles == 5000) begin
      n_errors++;
      complete_run;
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    sys_rst <= 1'b1;
    for (int k = 0; k < N_STAT; k++) status_words[k*DW +: DW] <= stat_word(k);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk_outs(16'h0, 1'b0, 48'h0, 32'h0, 64'h0);
    wr(OFS_SSEN, 32'habcd_1234, 4'h1, 0);
    wr(OFS_MCEN, 32'h0000_0001, 4'hf, 0);
    wr(OFS_MAC_LO, 32'h89ab_cdef, 4'hf, 0);
    wr(OFS_MAC_HI, 32'hffff_0246, 4'h3, 2);
    wr(OFS_IP, 32'hc0a8_0a05, 4'hf, 5);
    for (int n = 0; n < N_INST; n++) begin
      wr(OFS_WIN_BASE + 12'(n) * OFS_WIN_SPAN, {16'hffff, 16'h1000 + 16'(n)}, 4'hf, 0);
      wr(OFS_WIN_BASE + 12'(n) * OFS_WIN_SPAN + 12'h004, 32'h0000_dead, 4'hf, 0);
    end
    chk_outs(16'h1234, 1'b1, 48'h0246_89ab_cdef, 32'hc0a8_0a05, 64'h1003_1002_1001_1000);
    // writes that must change nothing
    wr(OFS_VER_BASE, 32'hffff_ffff, 4'hf, 0);
    wr(OFS_STAT, 32'hffff_ffff, 4'hf, 0);
    wr(12'hffc, 32'hffff_ffff, 4'hf, 0);
    wr(12'h5fc, 32'hffff_ffff, 4'hf, 0);
    chk_outs(16'h1234, 1'b1, 48'h0246_89ab_cdef, 32'hc0a8_0a05, 64'h1003_1002_1001_1000);
    wr(OFS_MCEN, 32'hffff_fffe, 4'hf, 0);
    check(64'(multicast_accept), 64'h0);
    // status reads with slow and prompt ready, then reads that return zero
    for (int k = 0; k < N_STAT; k++)
      rd(OFS_STAT + 12'(4 * k), k % 3, stat_word(k));
    rd(12'h840, 0, 32'h0);
    rd(12'hffc, 1, 32'h0);
    rd(OFS_SSEN, 0, 32'h0);
    rd(OFS_VER_BASE, 0, 32'h0);
    // write and read offered together
    fork
      wr(OFS_IP, 32'h0a00_0001, 4'hf, 0);
      rd(OFS_STAT + 12'h03c, 0, stat_word(15));
    join
    check(64'(local_ip), 64'h0a00_0001);
    // write offered while a read answer waits
    fork
      rd(OFS_STAT + 12'h004, 6, stat_word(1));
      begin
        repeat (2) @(posedge clk);
        wr(OFS_SSEN, 32'h0000_8001, 4'hf, 0);
      end
    join
    check(64'(session_enables), 64'h8001);
    complete_run;
  end
endmodule // arb_axil_regbank_tb
